// ---- hw/ilu_pkg.sv ----
package ilu_pkg;
  // instruction fields
  localparam int            MAJOR_MSB = 31;
  localparam int            MAJOR_LSB = 26;
  localparam int            BASE_MSB  = 25;
  localparam int            BASE_LSB  = 21;
  localparam int            INDEX_MSB = 20;
  localparam int            INDEX_LSB = 16;
  localparam int            RD_MSB    = 15;
  localparam int            RD_LSB    = 11;
  localparam int            SUBOP_MSB = 10;
  localparam int            SUBOP_LSB = 6;
  localparam int            FUNC_MSB  = 5;
  localparam int            FUNC_LSB  = 0;
  // encodings
  localparam logic [5:0]    EXTENSION_MAJOR_OPCODE   = 6'h1f;
  localparam logic [5:0]    INDEXED_LOAD_FUNCTION    = 6'h0a;
  localparam logic [4:0]    SUB_BYTE_UNSIGNED        = 5'h06;
  localparam logic [4:0]    SUB_DOUBLEWORD           = 5'h08;
  localparam logic [4:0]    SUB_HALFWORD             = 5'h04;
  localparam logic [4:0]    SUB_WORD                 = 5'h00;
  // widths
  localparam int            XLEN  = 64;
  localparam int            PALEN = 40;
  // access size codes to the memory system
  typedef enum logic [1:0] {
    ILU_SIZE_BYTE   = 2'h0,
    ILU_SIZE_HALF   = 2'h1,
    ILU_SIZE_WORD   = 2'h2,
    ILU_SIZE_DOUBLE = 2'h3
  } ilu_size_t;
  // exception cause codes
  typedef enum logic [2:0] {
    ILU_EXC_NONE     = 3'h0,
    ILU_EXC_RESERVED = 3'h1,
    ILU_EXC_DISABLED = 3'h2,
    ILU_EXC_REFILL   = 3'h3,
    ILU_EXC_INVALID  = 3'h4,
    ILU_EXC_BUS      = 3'h5,
    ILU_EXC_ADDRESS  = 3'h6,
    ILU_EXC_WATCH    = 3'h7
  } ilu_exc_t;
  // state machine, gray along the usual path
  typedef enum logic [1:0] {
    ILU_IDLE  = 2'b00,
    ILU_XLATE = 2'b01,
    ILU_MEM   = 2'b11,
    ILU_DONE  = 2'b10
  } ilu_state_t;
  localparam logic [XLEN-1:0] RESULT_RESET = 64'h0;
endpackage : ilu_pkg

// ---- hw/ilu_indexed_load_unit.sv ----
`timescale 1ns/1ps
// Behaviour
// RL1: the effective address is the sum of the index register and the base register.
// RL2: byte, halfword and word loads add only the low 32 bits of index and base.
// RL3: the doubleword load adds the full 64 bits of index and base.
// RL4: the unsigned byte load (opcode 011111, function 001010, sub-op 00110) is never misaligned and is zero-extended.
// RL5: for the unsigned byte load the two lowest physical address bits are xored with the byte order swap flag.
// RL6: the doubleword load (sub-op 01000) raises address error when any of the low three address bits is set.
// RL7: the doubleword load writes all 64 fetched bits unchanged.
// RL8: the halfword load (sub-op 00100) fetches 16 bits and sign-extends them to 64 bits.
// RL9: the halfword load raises address error when the lowest address bit is set.
// RL10: the word load (sub-op 00000) fetches 32 bits and sign-extends them to 64 bits.
// RL11: the word load raises address error when either of the two lowest address bits is set.
// RL12: each load can report reserved instruction, extension disabled, refill, invalid, bus and watch; all but the byte load can also report address.
// RL13: a failed alignment check issues no translation or read and writes no destination register.
// RL14: an exception from translation or memory suppresses the destination register write.
module ilu_indexed_load_unit
  import ilu_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  // issue from decode
  input  wire logic                     issue_valid,
  output logic                          issue_ready,
  input  wire logic [31:0]              issue_instr,
  input  wire logic [ilu_pkg::XLEN-1:0] issue_index_value,
  input  wire logic [ilu_pkg::XLEN-1:0] issue_base_value,
  input  wire logic                     extension_enabled,
  input  wire logic                     byte_order_swap_flag,
  // translation
  output logic                          xlate_req,
  output logic [ilu_pkg::XLEN-1:0]      xlate_vaddr,
  input  wire logic                     xlate_ack,
  input  wire logic [ilu_pkg::PALEN-1:0] xlate_paddr,
  input  wire logic                     xlate_refill,
  input  wire logic                     xlate_invalid,
  input  wire logic                     xlate_watch,
  // memory read
  output logic                          mem_req,
  output logic [ilu_pkg::PALEN-1:0]     mem_paddr,
  output ilu_pkg::ilu_size_t            mem_size,
  input  wire logic                     mem_ack,
  input  wire logic [ilu_pkg::XLEN-1:0] mem_rdata,
  input  wire logic                     mem_bus_error,
  // completion
  output logic                          done_valid,
  output logic                          wb_en,
  output logic [4:0]                    wb_reg,
  output logic [ilu_pkg::XLEN-1:0]      wb_data,
  output ilu_pkg::ilu_exc_t             exc_code,
  output logic [ilu_pkg::XLEN-1:0]      exc_badvaddr
);
  import ilu_pkg::*;

  function automatic logic [XLEN-1:0] ext_load(input ilu_size_t sz, input logic [XLEN-1:0] d);
    logic [XLEN-1:0] r;
    r = d;
    case (sz)
      ILU_SIZE_BYTE: r = {56'h0, d[7:0]}; // [RL4]
      ILU_SIZE_HALF: r = {{48{d[15]}}, d[15:0]}; // [RL8]
      ILU_SIZE_WORD: r = {{32{d[31]}}, d[31:0]}; // [RL10]
      default:       r = d; // [RL7]
    endcase
    return r;
  endfunction : ext_load

  // access size of a decoded sub-operation
  function automatic ilu_size_t size_of(input logic [4:0] s);
    ilu_size_t z;
    if (s == SUB_DOUBLEWORD) begin
      z = ILU_SIZE_DOUBLE;
    end else if (s == SUB_WORD) begin
      z = ILU_SIZE_WORD;
    end else if (s == SUB_HALFWORD) begin
      z = ILU_SIZE_HALF;
    end else begin
      z = ILU_SIZE_BYTE;
    end
    return z;
  endfunction : size_of

  // natural alignment check for an access size
  function automatic logic misaligned(input ilu_size_t sz, input logic [2:0] a);
    logic m;
    case (sz)
      ILU_SIZE_DOUBLE: m = a != 3'h0; // [RL6]
      ILU_SIZE_WORD:   m = a[1:0] != 2'h0; // [RL11]
      ILU_SIZE_HALF:   m = a[0]; // [RL9]
      default:         m = 1'b0; // [RL4]
    endcase
    return m;
  endfunction : misaligned

  // effective address; narrow loads keep only the low 32 bits of the sum
  function automatic logic [XLEN-1:0] eff_addr(
    input logic            wide,
    input logic [XLEN-1:0] idx,
    input logic [XLEN-1:0] bas
  );
    logic [31:0]     lo;
    logic [XLEN-1:0] r;
    lo = idx[31:0] + bas[31:0]; // [RL2]
    r  = idx + bas; // [RL3]
    if (!wide) begin
      r = {32'h0, lo};
    end
    return r;
  endfunction : eff_addr

  // byte lane swap for reversed byte order, byte loads only
  function automatic logic [PALEN-1:0] lane_adjust(
    input ilu_size_t        sz,
    input logic             swap,
    input logic [PALEN-1:0] pa
  );
    logic [PALEN-1:0] r;
    r = pa;
    if (sz == ILU_SIZE_BYTE) begin
      r[1:0] = pa[1:0] ^ {2{swap}}; // [RL5]
    end
    return r;
  endfunction : lane_adjust

  // translation cause: refill before invalid before watch
  function automatic ilu_exc_t xlate_cause(input logic refill, input logic invalid, input logic watch);
    ilu_exc_t c;
    c = ILU_EXC_NONE;
    if (refill) begin
      c = ILU_EXC_REFILL;
    end else if (invalid) begin
      c = ILU_EXC_INVALID;
    end else if (watch) begin
      c = ILU_EXC_WATCH;
    end
    return c;
  endfunction : xlate_cause

  // issue cause: reserved before disabled before address
  function automatic ilu_exc_t issue_cause(input logic known_op, input logic enabled, input logic mis);
    ilu_exc_t c;
    c = ILU_EXC_NONE;
    if (!known_op) begin
      c = ILU_EXC_RESERVED;
    end else if (!enabled) begin
      c = ILU_EXC_DISABLED;
    end else if (mis) begin
      c = ILU_EXC_ADDRESS;
    end
    return c;
  endfunction : issue_cause

  ilu_state_t      state_ff;
  ilu_state_t      nxt_state;
  ilu_size_t       size_ff;
  logic [XLEN-1:0] vaddr_ff;
  logic [PALEN-1:0] paddr_ff;
  logic [4:0]      rd_ff;
  logic            wb_en_ff;
  logic [XLEN-1:0] wb_data_ff;
  ilu_exc_t        exc_ff;
  logic            swap_ff;

  // decode
  wire logic [4:0]  subop     = issue_instr[SUBOP_MSB:SUBOP_LSB];
  wire logic        is_family = (issue_instr[MAJOR_MSB:MAJOR_LSB] == EXTENSION_MAJOR_OPCODE) &&
                                (issue_instr[FUNC_MSB:FUNC_LSB] == INDEXED_LOAD_FUNCTION);
  wire logic        is_byte   = subop == SUB_BYTE_UNSIGNED;
  wire logic        is_half   = subop == SUB_HALFWORD;
  wire logic        is_word   = subop == SUB_WORD;
  wire logic        is_double = subop == SUB_DOUBLEWORD;
  wire logic        known     = is_family && (is_byte || is_half || is_word || is_double);
  wire ilu_size_t   dec_size  = size_of(subop);

  // address generation
  wire logic [XLEN-1:0] eaddr    = eff_addr(is_double, issue_index_value, issue_base_value); // [RL1]
  wire logic            misalign = misaligned(dec_size, eaddr[2:0]); // [RL6] [RL9] [RL11]

  // physical address with byte lane adjust
  wire logic [PALEN-1:0] paddr_adj   = lane_adjust(size_ff, swap_ff, xlate_paddr); // [RL5]
  wire ilu_exc_t         xlate_code  = xlate_cause(xlate_refill, xlate_invalid, xlate_watch); // [RL12]
  wire logic             xlate_fault = xlate_code != ILU_EXC_NONE;
  wire ilu_exc_t         issue_code  = issue_cause(known, extension_enabled, misalign); // [RL12]
  wire logic             take        = issue_valid && (state_ff == ILU_IDLE);
  wire logic             xlate_done  = xlate_req && xlate_ack;
  wire logic             mem_done    = mem_req && mem_ack;

  assign issue_ready  = state_ff == ILU_IDLE;
  assign xlate_req    = state_ff == ILU_XLATE;
  assign xlate_vaddr  = vaddr_ff;
  assign mem_req      = state_ff == ILU_MEM;
  assign mem_paddr    = paddr_ff;
  assign mem_size     = size_ff;
  assign done_valid   = state_ff == ILU_DONE;
  assign wb_en        = done_valid && wb_en_ff;
  assign wb_reg       = rd_ff;
  assign wb_data      = wb_data_ff;
  assign exc_code     = done_valid ? exc_ff : ILU_EXC_NONE;
  assign exc_badvaddr = vaddr_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ILU_IDLE: begin
        if (take) begin
          nxt_state = (issue_code == ILU_EXC_NONE) ? ILU_XLATE : ILU_DONE; // [RL13]
        end
      end
      ILU_XLATE: begin
        if (xlate_ack) begin
          nxt_state = xlate_fault ? ILU_DONE : ILU_MEM; // [RL14]
        end
      end
      ILU_MEM: begin
        if (mem_ack) begin
          nxt_state = ILU_DONE;
        end
      end
      default: begin
        nxt_state = ILU_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= ILU_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // access size captured at issue
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      size_ff <= ILU_SIZE_BYTE;
    end else if (take) begin
      size_ff <= dec_size;
    end
  end

  // effective address captured at issue
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vaddr_ff <= RESULT_RESET;
    end else if (take) begin
      vaddr_ff <= eaddr;
    end
  end

  // destination register number
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_ff <= 5'h0;
    end else if (take) begin
      rd_ff <= issue_instr[RD_MSB:RD_LSB];
    end
  end

  // byte order swap captured at issue
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      swap_ff <= 1'b0;
    end else if (take) begin
      swap_ff <= byte_order_swap_flag;
    end
  end

  // physical address from translation
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      paddr_ff <= '0;
    end else if (xlate_done) begin
      paddr_ff <= paddr_adj; // [RL5]
    end
  end

  // extended load data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_data_ff <= RESULT_RESET;
    end else if (mem_done) begin
      wb_data_ff <= ext_load(size_ff, mem_rdata);
    end
  end

  // destination write enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_en_ff <= 1'b0;
    end else if (take) begin
      wb_en_ff <= 1'b0; // [RL13]
    end else if (mem_done) begin
      wb_en_ff <= !mem_bus_error; // [RL14]
    end
  end

  // exception cause
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      exc_ff <= ILU_EXC_NONE;
    end else if (take) begin
      exc_ff <= issue_code; // [RL12]
    end else if (xlate_done && xlate_fault) begin
      exc_ff <= xlate_code; // [RL14]
    end else if (mem_done) begin
      exc_ff <= mem_bus_error ? ILU_EXC_BUS : ILU_EXC_NONE; // [RL12]
    end
  end
endmodule : ilu_indexed_load_unit

// ---- verif/ilu_mem_model.sv ----
`timescale 1ns/1ps
module ilu_mem_model (
  // clock, reset, bench controls and requests from the unit
  input  wire logic        sys_clk, reset, slow, berr, xlate_req, mem_req,
  input  wire logic [1:0]  flt,
  input  wire logic [63:0] rdat, xlate_vaddr,
  // answers to the unit
  output logic             xlate_ack, xlate_refill, xlate_invalid, xlate_watch, mem_ack, mem_bus_error,
  output logic [39:0]      xlate_paddr,
  output logic [63:0]      mem_rdata
);
  logic [1:0] wait_ff;
  wire        go = (xlate_req | mem_req) & ~xlate_ack & ~mem_ack & (~slow | wait_ff == 2'h2);
  // identity translation; data lines toggle when not answering
  always_ff @(posedge sys_clk) begin
    wait_ff       <= reset | go ? 2'h0 : wait_ff + 2'h1;
    xlate_ack     <= ~reset & go & xlate_req;
    mem_ack       <= ~reset & go & mem_req;
    xlate_paddr   <= go ? xlate_vaddr[39:0] : ~xlate_paddr;
    xlate_refill  <= go & xlate_req & flt == 2'h1;
    xlate_invalid <= go & xlate_req & flt == 2'h2;
    xlate_watch   <= go & xlate_req & flt == 2'h3;
    mem_rdata     <= go ? rdat : ~mem_rdata;
    mem_bus_error <= go & mem_req & berr;
  end
endmodule : ilu_mem_model

// ---- verif/ilu_indexed_load_unit_sva.sv ----
`timescale 1ns/1ps
module ilu_indexed_load_unit_sva
  import ilu_pkg::*;
(
  // watched ports
  input wire logic                     sys_clk, reset, issue_valid, issue_ready, byte_order_swap_flag,
  input wire logic                     extension_enabled, xlate_req, xlate_ack, xlate_refill, xlate_invalid,
  input wire logic                     xlate_watch, mem_req, mem_ack, mem_bus_error, done_valid, wb_en,
  input wire logic [31:0]              issue_instr,
  input wire logic [ilu_pkg::XLEN-1:0]  issue_index_value, issue_base_value, xlate_vaddr, mem_rdata, wb_data,
  input wire logic [ilu_pkg::PALEN-1:0] xlate_paddr, mem_paddr,
  input wire ilu_pkg::ilu_size_t       mem_size,
  input wire ilu_pkg::ilu_exc_t        exc_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire [4:0]  sub  = issue_instr[SUBOP_MSB:SUBOP_LSB];
  wire [63:0] sum  = issue_index_value + issue_base_value;
  wire        fam  = issue_instr[31:26] == EXTENSION_MAJOR_OPCODE && issue_instr[5:0] == INDEXED_LOAD_FUNCTION
                     && sub inside {SUB_BYTE_UNSIGNED, SUB_DOUBLEWORD, SUB_HALFWORD, SUB_WORD};
  wire        mis  = sub == SUB_DOUBLEWORD ? |sum[2:0] : sub == SUB_WORD ? |sum[1:0] : sub == SUB_HALFWORD & sum[0];
  wire        take = issue_valid & issue_ready;
  wire        bad  = take & fam & extension_enabled & mis;
  logic [4:0]  sub_ff;
  logic        swap_ff;
  logic [63:0] s_ff;
  always_ff @(posedge sys_clk) if (take) {sub_ff, swap_ff, s_ff} <= {sub, byte_order_swap_flag, sum};
  wire        flt = xlate_refill | xlate_invalid | xlate_watch;
  property p_vaddr_dw; xlate_req && sub_ff == SUB_DOUBLEWORD |-> xlate_vaddr == s_ff; endproperty
  a_vaddr_dw: assert property (p_vaddr_dw) else $error("doubleword address wrong");
  property p_vaddr_nar; xlate_req && sub_ff != SUB_DOUBLEWORD |-> xlate_vaddr == {32'h0, s_ff[31:0]}; endproperty
  a_vaddr_nar: assert property (p_vaddr_nar) else $error("narrow address wrong");
  property p_align; bad |=> done_valid && exc_code == ILU_EXC_ADDRESS && !wb_en; endproperty
  a_align: assert property (p_align) else $error("misalignment not reported");
  property p_noreq; bad |=> (!xlate_req && !mem_req) [*2]; endproperty
  a_noreq: assert property (p_noreq) else $error("request after misalignment");
  property p_lane; xlate_ack && !flt && sub_ff == SUB_BYTE_UNSIGNED
    |=> mem_req && mem_paddr == ($past(xlate_paddr) ^ {38'h0, {2{swap_ff}}}); endproperty
  a_lane: assert property (p_lane) else $error("byte lane wrong");
  property p_size; $rose(mem_req) |-> mem_size == (sub_ff == SUB_DOUBLEWORD ? ILU_SIZE_DOUBLE : sub_ff == SUB_WORD
    ? ILU_SIZE_WORD : sub_ff == SUB_HALFWORD ? ILU_SIZE_HALF : ILU_SIZE_BYTE); endproperty
  a_size: assert property (p_size) else $error("access size wrong");
  property p_fault; xlate_ack && flt |=> done_valid && !wb_en && !mem_req; endproperty
  a_fault: assert property (p_fault) else $error("write after translation fault");
  property p_bus; mem_ack && mem_bus_error |=> done_valid && !wb_en && exc_code == ILU_EXC_BUS; endproperty
  a_bus: assert property (p_bus) else $error("bus error not reported");
  property p_zext; mem_ack && !mem_bus_error && sub_ff == SUB_BYTE_UNSIGNED
    |=> wb_en && wb_data == {56'h0, $past(mem_rdata[7:0])}; endproperty
  a_zext: assert property (p_zext) else $error("byte not zero extended");
  c_write: cover property (done_valid && wb_en);
  c_align: cover property (done_valid && exc_code == ILU_EXC_ADDRESS);
  c_bus: cover property (done_valid && exc_code == ILU_EXC_BUS);
endmodule : ilu_indexed_load_unit_sva
bind ilu_indexed_load_unit ilu_indexed_load_unit_sva u_sva (.*);

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  import ilu_pkg::*;
  logic sys_clk = 0, reset = 1, issue_valid = 0, extension_enabled = 1, byte_order_swap_flag = 0, slow = 0, berr = 0;
  logic [1:0]  flt = 0;
  logic [31:0] issue_instr = 0, seed = 32'hd6ec6d50, r;
  logic [63:0] issue_index_value = 0, issue_base_value = 0, rdat = 0;
  wire         xlate_req, xlate_ack, xlate_refill, xlate_invalid, xlate_watch, mem_req, mem_ack, mem_bus_error;
  wire         issue_ready, done_valid, wb_en;
  wire [4:0]   wb_reg;
  wire [39:0]  xlate_paddr, mem_paddr;
  wire [63:0]  xlate_vaddr, mem_rdata, wb_data, exc_badvaddr;
  wire ilu_size_t mem_size;
  wire ilu_exc_t  exc_code;
  int          miscompares = 0, compares = 0, cycles = 0;
  localparam logic [4:0] SUBS [4] = '{SUB_WORD, SUB_HALFWORD, SUB_DOUBLEWORD, SUB_BYTE_UNSIGNED};
  initial forever #4 sys_clk = ~sys_clk;
  ilu_indexed_load_unit uut (.*);
  ilu_mem_model partner (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) if (++cycles > 20000) begin miscompares++; tally_and_finish(); end
  // one load with reference model of address, exception and extension
  task automatic op(input logic [4:0] s);
    logic [63:0] a, x;
    ilu_exc_t    e;
    int          n;
    a = issue_index_value + issue_base_value;
    if (s != SUB_DOUBLEWORD) a = {32'h0, a[31:0]};
    e = !(s inside {SUBS[0], SUBS[1], SUBS[2], SUBS[3]}) ? ILU_EXC_RESERVED : !extension_enabled ? ILU_EXC_DISABLED
      : (s == SUB_DOUBLEWORD ? |a[2:0] : s == SUB_WORD ? |a[1:0] : s == SUB_HALFWORD & a[0]) ? ILU_EXC_ADDRESS
      : flt == 2'h3 ? ILU_EXC_WATCH : flt != 0 ? ilu_exc_t'(flt + 3'h2) : berr ? ILU_EXC_BUS : ILU_EXC_NONE;
    x = s == SUB_BYTE_UNSIGNED ? {56'h0, rdat[7:0]} : s == SUB_HALFWORD ? {{48{rdat[15]}}, rdat[15:0]}
      : s == SUB_WORD ? {{32{rdat[31]}}, rdat[31:0]} : rdat;
    issue_instr = {EXTENSION_MAJOR_OPCODE, 10'h0c4, 5'h09, s, INDEXED_LOAD_FUNCTION};
    issue_valid = 1;
    @(posedge sys_clk) #1 issue_valid = 0;
    n = 0;
    while (done_valid !== 1'b1 && n < 40) begin @(posedge sys_clk) #1 n++; end
    chk(done_valid, 1);
    chk(exc_code, e);
    chk(exc_badvaddr, a);
    chk(wb_en, e == ILU_EXC_NONE);
    if (e == ILU_EXC_NONE) chk(wb_data, x);
    if (e == ILU_EXC_NONE) chk(wb_reg, 5'h09);
    @(posedge sys_clk) #1;
  endtask : op
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 reset = 0;
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      {slow, byte_order_swap_flag} = r[1:0];
      flt = r[5:4] == 0 ? r[3:2] : 2'h0;
      berr = r[6] & r[7];
      extension_enabled = i != 7;
      issue_index_value = {rnd(), rnd()};
      issue_base_value = {rnd(), rnd()};
      rdat = {rnd(), rnd()};
      if (r[8]) issue_base_value -= (issue_index_value + issue_base_value) & 64'h7;
      op(i == 9 ? 5'h1f : SUBS[i % 4]);
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule : tb
